// File: rtl/lss_pkg.sv
// Constants for the serial port-status output engine.
// Assumes a 125 MHz core clock and an external shift-register chain.
package lss_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_BITS     = 36;
    localparam int unsigned PORTS_PER_LANE = 8;
    localparam int unsigned LANES          = 3;
    localparam int unsigned BITS_PER_PORT  = 4;

    // ------------------------------------------------------------------
    // Shift clock timing
    // ------------------------------------------------------------------
    localparam int unsigned CORE_CLK_MHZ   = 125;
    localparam int unsigned SHIFT_CLK_KHZ  = 2000;
    localparam int unsigned HALF_PERIOD_CYC =
        (CORE_CLK_MHZ * 1000) / (2 * SHIFT_CLK_KHZ);

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic        SHIFT_CLK_RESET = 1'b1;
    localparam logic        DATA_RESET      = 1'b0;

endpackage : lss_pkg

// File: rtl/lss_half_tick.sv
// Half-period tick generator for the indicator shift clock.
// Assumes clk_in is the core clock and ce_in gates all state.
`timescale 1ns/1ps

module lss_half_tick #(
    parameter int unsigned HALF_CYC = lss_pkg::HALF_PERIOD_CYC
) (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic ce_in,
    output logic      tick_out
);

    logic [15:0] cnt_q;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_q <= 16'h0000;
        end else if (ce_in) begin
            if (cnt_q == 16'(HALF_CYC - 1)) begin
                cnt_q <= 16'h0000;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    assign tick_out = ce_in && (cnt_q == 16'(HALF_CYC - 1));

endmodule // lss_half_tick

// File: rtl/lss_status_out.sv
// Serial port-status output engine: three indicator lanes, shift clock,
// and latch strobe. Assumes status inputs and mode on the core clock.
//
// Overview of operation
// [R1] Shift clock runs continuously, synchronous with data; here it stops and holds while ce_in is low.
// [R2] Lane 0: ports 1-8, then CPU port.
// [R3] Lane 1 ports 9-16; lane 2 ports 17-24.
// [R4] Data changes on shift clock falling edge.
// [R5] Receiver samples on rising shift clock edge.
// [R6] Mode 1 inverts lanes 1 and 2 data.
// [R7] Mode 1: strobe while clock low, bit 36.
// [R8] Mode 0: strobe unused, left unconnected.
// [R9] Frames repeat back to back, aligned.
`timescale 1ns/1ps

module lss_status_out #(
    parameter int unsigned FRAME_BITS = lss_pkg::FRAME_BITS,
    parameter int unsigned HALF_CYC   = lss_pkg::HALF_PERIOD_CYC
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_b_in,
    input  wire logic                    ce_in,
    input  wire logic                    mode_sel_in,
    input  wire logic [FRAME_BITS-1:0]   low_ports_status_in,
    input  wire logic [FRAME_BITS-1:0]   mid_ports_status_in,
    input  wire logic [FRAME_BITS-1:0]   high_ports_status_in,
    output logic                         indicator_shift_clock_out,
    output logic                         indicator_serial_out_low_ports_out,
    output logic                         indicator_serial_out_mid_ports_out,
    output logic                         indicator_serial_out_high_ports_out,
    output logic                         indicator_latch_strobe_out,
    output logic                         frame_start_out
);

    logic                  tick;
    logic                  sclk_q;
    logic [5:0]            bit_q;
    logic [FRAME_BITS-1:0] low_sh_q;
    logic [FRAME_BITS-1:0] mid_sh_q;
    logic [FRAME_BITS-1:0] high_sh_q;
    logic                  mode_q;
    logic                  fall;
    logic                  last_bit;

    lss_half_tick #(
        .HALF_CYC (HALF_CYC)
    ) u_tick (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .tick_out (tick)
    );

    // ------------------------------------------------------------------
    // Shift clock
    // ------------------------------------------------------------------
    assign fall     = tick && sclk_q;
    assign last_bit = (bit_q == 6'(FRAME_BITS - 1));

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            sclk_q <= lss_pkg::SHIFT_CLK_RESET;
        end else if (tick) begin
            sclk_q <= ~sclk_q; // [R1]
        end
    end

    // ------------------------------------------------------------------
    // Bit counter and frame alignment
    // ------------------------------------------------------------------
    // Bit index advances on each falling edge; wraps so frames abut.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            bit_q <= 6'(FRAME_BITS - 1);
        end else if (fall) begin
            bit_q <= last_bit ? 6'h00 : bit_q + 6'h01; // [R9]
        end
    end

    // Mode is taken at the frame boundary so a frame never mixes polarity.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            mode_q <= 1'b0;
        end else if (fall && last_bit) begin
            mode_q <= mode_sel_in;
        end
    end

    // ------------------------------------------------------------------
    // Shift registers
    // ------------------------------------------------------------------
    // Low lane: ports 1-8 occupy the upper 32 bits, CPU port the last 4.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            low_sh_q  <= '0;
            mid_sh_q  <= '0;
            high_sh_q <= '0;
        end else if (fall) begin
            if (last_bit) begin
                low_sh_q  <= low_ports_status_in;  // [R2]
                mid_sh_q  <= mid_ports_status_in;  // [R3]
                high_sh_q <= high_ports_status_in; // [R3]
            end else begin
                low_sh_q  <= {low_sh_q[FRAME_BITS-2:0], 1'b0};
                mid_sh_q  <= {mid_sh_q[FRAME_BITS-2:0], 1'b0};
                high_sh_q <= {high_sh_q[FRAME_BITS-2:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------------
    // Data registers update only on falling edges so they are stable at
    // the receiver's rising-edge sample point.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            indicator_serial_out_low_ports_out  <= lss_pkg::DATA_RESET;
            indicator_serial_out_mid_ports_out  <= lss_pkg::DATA_RESET;
            indicator_serial_out_high_ports_out <= lss_pkg::DATA_RESET;
        end else if (fall) begin
            if (last_bit) begin
                indicator_serial_out_low_ports_out  <=
                    low_ports_status_in[FRAME_BITS-1]; // [R4] [R5]
                indicator_serial_out_mid_ports_out  <=
                    mid_ports_status_in[FRAME_BITS-1] ^ mode_sel_in; // [R6]
                indicator_serial_out_high_ports_out <=
                    high_ports_status_in[FRAME_BITS-1] ^ mode_sel_in; // [R6]
            end else begin
                indicator_serial_out_low_ports_out  <= low_sh_q[FRAME_BITS-2]; // [R4]
                indicator_serial_out_mid_ports_out  <= mid_sh_q[FRAME_BITS-2] ^ mode_q;
                indicator_serial_out_high_ports_out <= high_sh_q[FRAME_BITS-2] ^ mode_q;
            end
        end
    end

    // Strobe covers the low half of the 36th bit in mode 1 only.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            indicator_latch_strobe_out <= 1'b0;
        end else if (fall) begin
            indicator_latch_strobe_out <= mode_q && (bit_q == 6'(FRAME_BITS - 2)); // [R7] [R8]
        end else if (tick) begin
            indicator_latch_strobe_out <= 1'b0;
        end
    end

    assign indicator_shift_clock_out = sclk_q;
    assign frame_start_out           = fall && last_bit;

endmodule // lss_status_out

// File: tb/lss_chk.sv
// Checker for the serial port-status output engine.
// Assumes binding to lss_status_out; attempts that meet a clock-enable freeze are dropped.
`timescale 1ns/1ps
module lss_chk #(
    parameter int unsigned FRAME_BITS = 36,
    parameter int unsigned HALF_CYC   = 2
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic mode_sel_in,
    input wire logic indicator_shift_clock_out,
    input wire logic indicator_serial_out_low_ports_out,
    input wire logic indicator_serial_out_mid_ports_out,
    input wire logic indicator_serial_out_high_ports_out,
    input wire logic indicator_latch_strobe_out,
    input wire logic frame_start_out
);
    localparam int H  = HALF_CYC;
    localparam int FC = 2 * H * FRAME_BITS;
    localparam int SD = FC - 2 * H + 1;
    wire  sc = indicator_shift_clock_out;
    wire  st = indicator_latch_strobe_out;
    logic mode_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in || !ce_in);
    // Mode in force for the frame now being shifted.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) mode_q <= 1'b0;
        else if (frame_start_out) mode_q <= mode_sel_in;
    end
    property p_dedge;
        ($changed(indicator_serial_out_low_ports_out) || $changed(indicator_serial_out_mid_ports_out)
         || $changed(indicator_serial_out_high_ports_out)) |-> $fell(sc);
    endproperty
    a_dedge: assert property (p_dedge) else $error("data moved off a clock fall");
    property p_hlow; $fell(sc) |-> ##H $rose(sc); endproperty
    a_hlow: assert property (p_hlow) else $error("low half wrong");
    property p_hhigh; $rose(sc) |-> ##H $fell(sc); endproperty
    a_hhigh: assert property (p_hhigh) else $error("high half wrong");
    property p_strise; $rose(st) |-> $fell(sc); endproperty
    a_strise: assert property (p_strise) else $error("strobe not on fall");
    property p_stwidth; $rose(st) |-> ##H ($fell(st) && $rose(sc)); endproperty
    a_stwidth: assert property (p_stwidth) else $error("strobe width wrong");
    property p_stpos; frame_start_out && mode_sel_in |-> ##SD $rose(st); endproperty
    a_stpos: assert property (p_stpos) else $error("strobe not at last bit");
    property p_m0; !mode_q |-> !st; endproperty
    a_m0: assert property (p_m0) else $error("strobe in mode 0");
    property p_frame; frame_start_out |-> ##FC frame_start_out; endproperty
    a_frame: assert property (p_frame) else $error("frame spacing wrong");
    c_strobe: cover property (st);
    c_m1: cover property (frame_start_out && mode_sel_in);
    c_m0: cover property (frame_start_out && !mode_sel_in);
endmodule // lss_chk

// File: tb/lss_led_chain.sv
// Model of the external indicator shift-register chain.
// Assumes clock, data and strobe come straight from the engine pins.
`timescale 1ns/1ps
module lss_led_chain (
    input  wire logic        clk_in,
    input  wire logic        sclk_in,
    input  wire logic        strobe_in,
    input  wire logic [2:0]  data_in,
    output logic      [35:0] shift_out [3],
    output logic      [35:0] latch_out [3]
);
    logic sclk_q;
    logic strobe_q;
    always_ff @(posedge clk_in) begin
        sclk_q   <= sclk_in;
        strobe_q <= strobe_in;
        if (sclk_in && !sclk_q) begin
            for (int i = 0; i < 3; i++) begin
                shift_out[i] <= {shift_out[i][34:0], data_in[i]};
                if (strobe_q)
                    latch_out[i] <= {shift_out[i][34:0], data_in[i]};
            end
        end
    end
endmodule // lss_led_chain

// File: tb/tb_lss_status_out.sv
// Self-checking bench for the serial port-status output engine.
// Assumes a half period of two core cycles so frames run quickly.
`timescale 1ns/1ps
module tb_lss_status_out;
    logic        clk_in      = 1'b0;
    logic        rst_b_in    = 1'b0;
    logic        mode_sel_in = 1'b0;
    logic        ce          = 1'b1;
    logic [35:0] lo          = 36'h0;
    logic [35:0] mi          = 36'h0;
    logic [35:0] hi          = 36'h0;
    logic        sclk;
    logic        stb;
    logic        fs;
    logic [2:0]  d;
    logic [35:0] sh [3];
    logic [35:0] lt [3];
    int          miscompares     = 0;
    int          samples_checked = 0;
    always #4 clk_in = ~clk_in;
    lss_status_out #(.HALF_CYC(2)) i_dut (.clk_in, .rst_b_in, .ce_in(ce), .mode_sel_in,
        .low_ports_status_in(lo), .mid_ports_status_in(mi), .high_ports_status_in(hi),
        .indicator_shift_clock_out(sclk), .indicator_serial_out_low_ports_out(d[0]),
        .indicator_serial_out_mid_ports_out(d[1]), .indicator_serial_out_high_ports_out(d[2]),
        .indicator_latch_strobe_out(stb), .frame_start_out(fs));
    lss_led_chain i_chain (.clk_in, .sclk_in(sclk), .strobe_in(stb), .data_in(d),
        .shift_out(sh), .latch_out(lt));
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_fs();
        int n;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (fs !== 1'b1 && n < 400);
        if (fs !== 1'b1) begin
            miscompares++;
            end_sim();
        end
    endtask
    // Loads one frame, lets it shift out whole, then compares the chain.
    task automatic run_frame(input logic m, input logic [35:0] a, b, c);
        @(negedge clk_in);
        mode_sel_in = m;
        lo = a;
        mi = b;
        hi = c;
        wait_fs();
        wait_fs();
        check(sh[0], a);
        check(sh[1], b ^ {36{m}});
        check(sh[2], c ^ {36{m}});
        if (m) check(lt[2], c ^ {36{m}});
    endtask
    task automatic t_plain();
        run_frame(1'b0, 36'h123456789, 36'hA5A5A5A50, 36'h0F0F0F0F1);
    endtask
    task automatic t_invert();
        run_frame(1'b1, 36'h876543210, 36'h5A5A5A5AF, 36'hC3C3C3C3C);
    endtask
    task automatic t_extremes();
        run_frame(1'b1, 36'hFFFFFFFFF, 36'h000000000, 36'hFFFFFFFFF);
        run_frame(1'b0, 36'h000000001, 36'h800000000, 36'hAAAAAAAAA);
    endtask
    // Freezes the engine mid-frame, then checks shift clock and data pins held and a clean frame after.
    task automatic t_freeze();
        logic [3:0] held;
        wait_fs();
        repeat (10) @(negedge clk_in);
        ce = 1'b0;
        held = {sclk, d};
        repeat (20) @(negedge clk_in);
        check({32'h0, sclk, d}, {32'h0, held});
        ce = 1'b1;
        run_frame(1'b1, 36'h13579BDF0, 36'h2468ACE01, 36'hFEDCBA987);
    endtask
    initial begin
        repeat (5) @(negedge clk_in);
        rst_b_in = 1'b1;
        t_plain();
        t_invert();
        t_extremes();
        t_freeze();
        end_sim();
    end
endmodule // tb_lss_status_out
bind lss_status_out lss_chk #(.FRAME_BITS(FRAME_BITS), .HALF_CYC(HALF_CYC)) i_chk (.clk_in,
    .rst_b_in, .ce_in, .mode_sel_in, .indicator_shift_clock_out, .indicator_serial_out_low_ports_out,
    .indicator_serial_out_mid_ports_out, .indicator_serial_out_high_ports_out,
    .indicator_latch_strobe_out, .frame_start_out);
